// File: hdl/adc_fmt_pkg.sv
// shared constants and types for the converter output format block
package adc_fmt_pkg;
   localparam int SAMPLE_W = 14; // converter sample width
   localparam int NUM_VC = 8; // virtual converters with an overrange flag
   localparam int ADR_W = 14; // wishbone byte address width
   localparam int IDX_W = 12; // register index width (byte address / 4)
   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_TEST_MODE = 12'h550;
   localparam logic [IDX_W-1:0] IDX_PAT3_LO = 12'h555;
   localparam logic [IDX_W-1:0] IDX_PAT3_HI = 12'h556;
   localparam logic [IDX_W-1:0] IDX_PAT4_LO = 12'h557;
   localparam logic [IDX_W-1:0] IDX_PAT4_HI = 12'h558;
   localparam logic [IDX_W-1:0] IDX_STATUS_SEL = 12'h559;
   localparam logic [IDX_W-1:0] IDX_FORMAT = 12'h561;
   localparam logic [IDX_W-1:0] IDX_OR_CLEAR = 12'h562;
   localparam logic [IDX_W-1:0] IDX_OR_FLAGS = 12'h563;
   localparam logic [IDX_W-1:0] IDX_CHAN_ORDER = 12'h564;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 12'h5F0;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 12'h5F1;
   // values after reset
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_FORMAT = 8'h01;
   // field positions
   localparam int TM_SINGLE_BIT = 7; // test mode: 1 = emit pattern once
   localparam int FMT_INVERT_BIT = 2; // output mode: sample invert
   localparam int SWAP_BIT = 0; // channel order: swap enable
   // field encodings
   localparam logic [3:0] TM_USER_PATTERN = 4'h8;
   localparam logic [1:0] FMT_OFFSET = 2'h0;
   localparam logic [1:0] FMT_TWOS = 2'h1;
   localparam logic [2:0] ST_TIE_LOW = 3'h0;
   localparam logic [2:0] ST_OVERRANGE = 3'h1;
   localparam logic [2:0] ST_SIG_MON = 3'h2;
   localparam logic [2:0] ST_FAST_DET = 3'h3;
   localparam logic [2:0] ST_SYSREF = 3'h5;
   // pattern sequencer states, one-hot
   typedef enum logic [3:0] {
      PAT_IDLE = 4'b0001,
      PAT_THREE = 4'b0010,
      PAT_FOUR = 4'b0100,
      PAT_DONE = 4'b1000
   } pat_state_e;
   // one sample from each converter channel
   typedef struct packed {
      logic [SAMPLE_W-1:0] a;
      logic [SAMPLE_W-1:0] b;
   } sample_pair_s;
endpackage

// File: hdl/sample_formatter.sv
// per-channel sample word formatting: offset binary or twos complement, optional invert
module sample_formatter
   import adc_fmt_pkg::*;
(
   input wire logic [SAMPLE_W-1:0] raw,
   input wire logic [1:0] format,
   input wire logic invert,
   output logic [SAMPLE_W-1:0] formatted
);
   logic [SAMPLE_W-1:0] coded; // after format conversion

   // raw samples arrive as offset binary; twos complement flips the msb
   // unlisted format codes fall back to offset binary
   always_comb begin
      coded = raw;
      if (format == FMT_TWOS) begin
         coded[SAMPLE_W-1] = ~raw[SAMPLE_W-1];
      end
      formatted = invert ? ~coded : coded;
   end
endmodule

// File: hdl/adc_output_format_control.sv
// register bank and output stage of the converter digital output formatter
// How it works
// [R1] status select: tie-low or overrange choices
// [R2] status select: monitor, fast detect, sysref
// [R3] format field: 00 offset, 01 twos
// [R4] invert bit inverts every formatted sample; user pattern words are not inverted
// [R5] overrange clear bit 1 clears flag
// [R6] read-only overrange flags per virtual converter
// [R7] swap bit exchanges the two channels
// [R8] user pattern three/four byte registers
// [R9] user pattern repeats or runs once
// [R10] flags sticky; detection off while clearing
// [R11] format and invert before channel swap
module adc_output_format_control
   import adc_fmt_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire sample_pair_s samples_in,
   input wire logic [NUM_VC-1:0] overrange_in,
   input wire logic signal_monitor,
   input wire logic fast_detect_flag,
   input wire logic sysref_pin,
   output sample_pair_s samples_out,
   output logic status_out,
   output logic irq
);
   // register index of the current bus access
   logic [IDX_W-1:0] idx;
   assign idx = wb_adr_i[ADR_W-1:2];

   // true when the access index matches a register
   function automatic logic hit(input logic [IDX_W-1:0] a, input logic [IDX_W-1:0] r);
      hit = (a == r);
   endfunction

   logic req; // new request not yet answered
   logic wr_lane0; // write that carries the low byte lane
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_lane0 = req & wb_we_i & wb_sel_i[0];

   logic [7:0] test_mode_q; // pattern select bit and test mode field
   logic [7:0] pat3_lo_q, pat3_hi_q, pat4_lo_q, pat4_hi_q; // user pattern bytes
   logic [7:0] status_sel_q; // status source select
   logic [7:0] format_q; // sample invert and data format
   logic [7:0] or_clear_q; // per-converter overrange clear
   logic [NUM_VC-1:0] or_flags_q; // sticky overrange flags
   logic [7:0] chan_order_q; // channel swap
   logic [NUM_VC-1:0] irq_stat_q; // sticky new-overrange events
   logic [NUM_VC-1:0] irq_mask_q; // interrupt enables
   logic [NUM_VC-1:0] or_event; // overrange seen while detection enabled
   logic sysref_s1_q, sysref_s2_q; // pin synchroniser

   // bus answer: one wait state, ack for exactly one cycle
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // read mux; unmapped indices read as zero and still get an ack
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req) begin
         unique case (1'b1)
            hit(idx, IDX_TEST_MODE): wb_dat_o <= {24'h00_0000, test_mode_q};
            hit(idx, IDX_PAT3_LO): wb_dat_o <= {24'h00_0000, pat3_lo_q};
            hit(idx, IDX_PAT3_HI): wb_dat_o <= {24'h00_0000, pat3_hi_q};
            hit(idx, IDX_PAT4_LO): wb_dat_o <= {24'h00_0000, pat4_lo_q};
            hit(idx, IDX_PAT4_HI): wb_dat_o <= {24'h00_0000, pat4_hi_q};
            hit(idx, IDX_STATUS_SEL): wb_dat_o <= {24'h00_0000, status_sel_q};
            hit(idx, IDX_FORMAT): wb_dat_o <= {24'h00_0000, format_q};
            hit(idx, IDX_OR_CLEAR): wb_dat_o <= {24'h00_0000, or_clear_q};
            hit(idx, IDX_OR_FLAGS): wb_dat_o <= {24'h00_0000, or_flags_q}; // R6
            hit(idx, IDX_CHAN_ORDER): wb_dat_o <= {24'h00_0000, chan_order_q};
            hit(idx, IDX_IRQ_STATUS): wb_dat_o <= {24'h00_0000, irq_stat_q};
            hit(idx, IDX_IRQ_MASK): wb_dat_o <= {24'h00_0000, irq_mask_q};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // plain read/write configuration registers; reserved bits stay zero
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         test_mode_q <= RST_ZERO;
         pat3_lo_q <= RST_ZERO;
         pat3_hi_q <= RST_ZERO;
         pat4_lo_q <= RST_ZERO;
         pat4_hi_q <= RST_ZERO;
         status_sel_q <= RST_ZERO;
         format_q <= RST_FORMAT; // R3
         or_clear_q <= RST_ZERO;
         chan_order_q <= RST_ZERO;
         irq_mask_q <= RST_ZERO;
      end else if (wr_lane0) begin
         if (hit(idx, IDX_TEST_MODE)) test_mode_q <= {wb_dat_i[7], 3'h0, wb_dat_i[3:0]};
         if (hit(idx, IDX_PAT3_LO)) pat3_lo_q <= wb_dat_i[7:0]; // R8
         if (hit(idx, IDX_PAT3_HI)) pat3_hi_q <= wb_dat_i[7:0]; // R8
         if (hit(idx, IDX_PAT4_LO)) pat4_lo_q <= wb_dat_i[7:0]; // R8
         if (hit(idx, IDX_PAT4_HI)) pat4_hi_q <= wb_dat_i[7:0]; // R8
         if (hit(idx, IDX_STATUS_SEL)) status_sel_q <= {5'h00, wb_dat_i[2:0]};
         if (hit(idx, IDX_FORMAT)) format_q <= {5'h00, wb_dat_i[2:0]};
         if (hit(idx, IDX_OR_CLEAR)) or_clear_q <= wb_dat_i[7:0]; // R5
         if (hit(idx, IDX_CHAN_ORDER)) chan_order_q <= {7'h00, wb_dat_i[0]};
         if (hit(idx, IDX_IRQ_MASK)) irq_mask_q <= wb_dat_i[7:0];
      end
   end

   // overrange flags: sticky, cleared and held clear while the clear bit is set;
   // here the clear deliberately beats a same-cycle overrange
   assign or_event = overrange_in & ~or_clear_q; // R10
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         or_flags_q <= RST_ZERO;
      end else begin
         or_flags_q <= (or_flags_q | or_event) & ~or_clear_q; // R5 R10
      end
   end

   // interrupt status: a flag rising sets its bit; write one to clear, set wins
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irq_stat_q <= RST_ZERO;
      end else begin
         irq_stat_q <= (irq_stat_q & ~((wr_lane0 && hit(idx, IDX_IRQ_STATUS)) ?
            wb_dat_i[7:0] : 8'h00)) | (or_event & ~or_flags_q);
      end
   end

   // level interrupt, one cycle behind the status bits
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   // system reference arrives from a pin: two flops before any use
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sysref_s1_q <= 1'b0;
         sysref_s2_q <= 1'b0;
      end else begin
         sysref_s1_q <= sysref_pin;
         sysref_s2_q <= sysref_s1_q;
      end
   end

   // status output mux; unlisted codes read as low
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         status_out <= 1'b0;
      end else begin
         unique case (status_sel_q[2:0])
            ST_TIE_LOW: status_out <= 1'b0; // R1
            ST_OVERRANGE: status_out <= |overrange_in; // R1
            ST_SIG_MON: status_out <= signal_monitor; // R2
            ST_FAST_DET: status_out <= fast_detect_flag; // R2
            ST_SYSREF: status_out <= sysref_s2_q; // R2
            default: status_out <= 1'b0;
         endcase
      end
   end

   // user pattern sequencer: word three then word four, looped or once
   pat_state_e pat_q;
   logic user_mode; // user pattern test mode selected
   assign user_mode = (test_mode_q[3:0] == TM_USER_PATTERN);
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pat_q <= PAT_IDLE;
      end else if (!user_mode) begin
         pat_q <= PAT_IDLE; // leaving the mode rearms a single run
      end else begin
         unique case (pat_q)
            PAT_IDLE: pat_q <= PAT_THREE;
            PAT_THREE: pat_q <= PAT_FOUR;
            PAT_FOUR: pat_q <= test_mode_q[TM_SINGLE_BIT] ? PAT_DONE : PAT_THREE; // R9
            PAT_DONE: pat_q <= PAT_DONE;
            default: pat_q <= PAT_IDLE;
         endcase
      end
   end

   // both channels formatted in parallel, before any swap
   logic [SAMPLE_W-1:0] fmt [2]; // formatted channel a (0) and b (1)
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_fmt
         sample_formatter u_fmt (
            .raw(g == 0 ? samples_in.a : samples_in.b),
            .format(format_q[1:0]), // R3
            .invert(format_q[FMT_INVERT_BIT]), // R4
            .formatted(fmt[g])
         );
      end
   endgenerate

   // output stage: pattern words msb-justified in place of samples, else
   // formatted samples with optional swap; formatting cost is paid before
   // the swap so both outputs always share one format
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         samples_out <= '0;
      end else if (user_mode) begin
         unique case (pat_q)
            PAT_THREE: samples_out <= {2{pat3_hi_q, pat3_lo_q[7:2]}}; // R8
            PAT_FOUR: samples_out <= {2{pat4_hi_q, pat4_lo_q[7:2]}}; // R8
            default: samples_out <= '0;
         endcase
      end else if (chan_order_q[SWAP_BIT]) begin
         samples_out <= {fmt[1], fmt[0]}; // R7 R11
      end else begin
         samples_out <= {fmt[0], fmt[1]}; // R7
      end
   end

   // checks below sample on the rising edge and sleep while reset is applied
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   sequence s_wr_pat3_lo;
      req && wb_we_i && wb_sel_i[0] && hit(idx, IDX_PAT3_LO) ##1 wb_ack_o;
   endsequence
   property p_pat3_write;
      s_wr_pat3_lo |-> pat3_lo_q == $past(wb_dat_i[7:0]);
   endproperty
   a_pat3_write: assert property (p_pat3_write) else $error("pattern byte not stored"); // R8

   property p_tie_low;
      status_sel_q[2:0] == ST_TIE_LOW |=> !status_out;
   endproperty
   a_tie_low: assert property (p_tie_low) else $error("tied-low status went high"); // R1

   property p_fast_detect;
      status_sel_q[2:0] == ST_FAST_DET |=> status_out == $past(fast_detect_flag);
   endproperty
   a_fast_detect: assert property (p_fast_detect) else $error("fast detect not routed"); // R2

   property p_twos;
      !user_mode && format_q[2:0] == {1'b0, FMT_TWOS} && !chan_order_q[SWAP_BIT] |=>
         samples_out.a == {~$past(samples_in.a[SAMPLE_W-1]), $past(samples_in.a[SAMPLE_W-2:0])};
   endproperty
   a_twos: assert property (p_twos) else $error("twos complement wrong"); // R3

   property p_invert;
      !user_mode && format_q[2:0] == 3'h4 && !chan_order_q[SWAP_BIT] |=>
         samples_out.b == ~$past(samples_in.b);
   endproperty
   a_invert: assert property (p_invert) else $error("inverted offset sample wrong"); // R4

   property p_clear;
      |or_clear_q |=> (or_flags_q & $past(or_clear_q)) == 8'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("cleared flag still set"); // R5

   property p_sticky;
      (or_flags_q | or_event) != 8'h00 ##1 or_clear_q == 8'h00 |->
         (or_flags_q & ($past(or_flags_q) | $past(or_event)))
            == ($past(or_flags_q) | $past(or_event));
   endproperty
   a_sticky: assert property (p_sticky) else $error("overrange flag lost"); // R6 R10

   property p_swap;
      !user_mode && chan_order_q[SWAP_BIT] |=>
         samples_out.a == $past(fmt[1]) && samples_out.b == $past(fmt[0]);
   endproperty
   a_swap: assert property (p_swap) else $error("channel swap wrong"); // R7 R11

   sequence s_single_run;
      user_mode && test_mode_q[TM_SINGLE_BIT] && pat_q == PAT_FOUR;
   endsequence
   property p_single;
      s_single_run ##1 user_mode |-> pat_q == PAT_DONE ##1 (!user_mode || samples_out == '0);
   endproperty
   a_single: assert property (p_single) else $error("single pattern repeated"); // R9

   property p_repeat;
      user_mode && !test_mode_q[TM_SINGLE_BIT] && pat_q == PAT_FOUR ##1 user_mode |->
         pat_q == PAT_THREE;
   endproperty
   a_repeat: assert property (p_repeat) else $error("pattern did not loop"); // R9

   property p_irq;
      (irq_stat_q & irq_mask_q) != 8'h00 |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule

// File: test/sample_receiver.sv
// downstream receiver model: registers each formatted sample pair and status bit
module sample_receiver
   import adc_fmt_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire sample_pair_s pair_in,
   input wire logic status_in,
   output sample_pair_s pair_q,
   output logic status_q
);
   timeunit 1ns;
   timeprecision 1ps;
   // capture every edge; a real receiver adds this one stage of latency
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pair_q <= '0;
         status_q <= 1'b0;
      end else begin
         pair_q <= pair_in;
         status_q <= status_in;
      end
   end
endmodule

// File: test/adc_output_format_control_test.sv
// self-checking bench for the converter output format block
module adc_output_format_control_test
   import adc_fmt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {int due; logic k; logic [27:0] v;} note_s; // k set: status note
   localparam logic [13:0] W3 = {8'hA5, 6'h0F}; // pattern three word
   localparam logic [13:0] W4 = {8'h5A, 6'h30}; // pattern four word
   logic clock = 0;
   logic nrst = 0;
   logic cyc_i = 0;
   logic stb = 0;
   logic we = 0;
   logic [ADR_W-1:0] adr = '0;
   logic [3:0] sel = '0;
   logic [31:0] wdat = '0;
   logic [31:0] rdat;
   logic ack, st, irq, st_rx;
   sample_pair_s s_in = '0;
   sample_pair_s s_out, s_rx;
   logic [NUM_VC-1:0] ovr = '0;
   logic mon = 0;
   logic fdet = 0;
   logic sref = 0;
   int cnt = 0; // cycles since start
   int errors = 0;
   int total_checks = 0;
   logic [15:0] lf = 16'h0012; // random source, seeded with 18
   logic [31:0] rd_q[$]; // expected read data
   note_s n_q[$]; // expected receiver values with due cycle
   logic [11:0] ridx[13] = '{12'h561, 12'h555, 12'h556, 12'h557, 12'h558, 12'h559, 12'h562,
      12'h563, 12'h564, 12'h550, 12'h5F0, 12'h5F1, 12'h100};
   logic [11:0] widx[10] = '{12'h555, 12'h556, 12'h557, 12'h558, 12'h559, 12'h561, 12'h562,
      12'h564, 12'h563, 12'h100};
   logic [7:0] wmsk[10] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h07, 8'hFF, 8'h01, 8'h00, 8'h00};
   logic [2:0] codes[4] = '{ST_OVERRANGE, ST_SIG_MON, ST_FAST_DET, ST_SYSREF};
   always #4 clock = ~clock;
   adc_output_format_control dut_u (.clock(clock), .nrst(nrst), .wb_cyc_i(cyc_i),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .samples_in(s_in), .overrange_in(ovr),
      .signal_monitor(mon), .fast_detect_flag(fdet), .sysref_pin(sref),
      .samples_out(s_out), .status_out(st), .irq(irq));
   sample_receiver rx_u (.clock(clock), .nrst(nrst), .pair_in(s_out), .status_in(st),
      .pair_q(s_rx), .status_q(st_rx));
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // expected word: twos flips the msb of offset binary, invert after that
   function automatic logic [13:0] fm(input logic [13:0] x, input logic [2:0] c);
      logic [13:0] y;
      y = (c[1:0] == FMT_TWOS) ? {~x[13], x[12:0]} : x;
      return c[2] ? ~y : y;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t %s seen %h want %h", $time, what, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // one classic cycle; holds everything until ack is sampled, bounded wait
   task automatic bus(input logic [11:0] i, input logic w, input logic [7:0] d,
      input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clock);
      cyc_i <= 1;
      stb <= 1;
      we <= w;
      adr <= {i, 2'b00};
      wdat <= {24'h0, d};
      sel <= s;
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1 && n < 40);
      if (n >= 40) errors++;
      cyc_i <= 0;
      stb <= 0;
   endtask
   task automatic wr(input logic [11:0] i, input logic [7:0] d);
      bus(i, 1'b1, d, 4'hF);
   endtask
   task automatic rd(input logic [11:0] i, input logic [7:0] e);
      rd_q.push_back({24'h0, e});
      bus(i, 1'b0, 8'h00, 4'hF);
   endtask
   // random raw pair; receiver sees it three counts later
   task automatic smp(input logic [2:0] c, input logic sw);
      logic [13:0] a, b;
      lf = nxt(lf);
      a = lf[13:0];
      lf = nxt(lf);
      b = lf[13:0];
      @(posedge clock);
      s_in <= {a, b};
      n_q.push_back('{cnt + 3, 1'b0, sw ? {fm(b, c), fm(a, c)} : {fm(a, c), fm(b, c)}});
   endtask
   // hold sources six cycles: covers the synchroniser on the reference pin
   task automatic srcs(input logic [3:0] on, input logic e);
      @(posedge clock);
      ovr <= {2'b0, on[0], 5'b0};
      mon <= on[1];
      fdet <= on[2];
      sref <= on[3];
      n_q.push_back('{cnt + 6, 1'b1, {27'h0, e}});
      repeat (6) @(posedge clock);
   endtask
   task automatic pulse(input int b);
      @(posedge clock);
      ovr <= 8'h01 << b;
      @(posedge clock);
      ovr <= '0;
   endtask
   // wait for the first pattern word, then the rest follow one per cycle
   task automatic pat(input logic [7:0] m, input logic once);
      int n;
      n = 0;
      wr(IDX_TEST_MODE, m);
      while (s_rx === '0 && n < 20) begin
         @(negedge clock);
         n++;
      end
      chk({4'h0, s_rx}, {4'h0, W3, W3}, "pattern");
      n_q.push_back('{cnt + 1, 1'b0, {W4, W4}});
      n_q.push_back('{cnt + 2, 1'b0, once ? 28'h0 : {W3, W3}});
      n_q.push_back('{cnt + 3, 1'b0, once ? 28'h0 : {W4, W4}});
      repeat (4) @(posedge clock);
   endtask
   // watcher: read data while ack stands, receiver values when due
   always @(negedge clock) begin
      note_s n;
      if (ack === 1'b1 && rd_q.size() > 0) chk(rdat, rd_q.pop_front(), "read");
      while (n_q.size() > 0 && n_q[0].due <= cnt) begin
         n = n_q.pop_front();
         if (n.k) chk({31'h0, st_rx}, {31'h0, n.v[0]}, "status");
         else chk({4'h0, s_rx}, {4'h0, n.v}, "sample");
      end
   end
   // cycle count and hang guard
   always @(posedge clock) begin
      cnt <= cnt + 1;
      if (cnt > 30000) begin
         errors++;
         complete_run();
      end
   end
   initial begin
      repeat (10) @(posedge clock);
      nrst <= 1;
      foreach (ridx[i]) rd(ridx[i], i == 0 ? RST_FORMAT : RST_ZERO);
      foreach (widx[i]) begin
         wr(widx[i], 8'hFF);
         rd(widx[i], wmsk[i]);
      end
      // lane zero disabled must leave the byte alone
      for (int i = 0; i < 4; i++) begin
         lf = nxt(lf);
         wr(IDX_PAT3_LO + 12'(i), lf[7:0]);
         bus(IDX_PAT3_LO + 12'(i), 1'b1, ~lf[7:0], 4'hE);
         rd(IDX_PAT3_LO + 12'(i), lf[7:0]);
      end
      // clear held at all ones so no flag sets while sources toggle
      for (int c = 0; c < 8; c++) begin
         wr(IDX_STATUS_SEL, {5'h0, 3'(c)});
         for (int j = 0; j < 4; j++) srcs(4'h1 << j, 3'(c) == codes[j]);
      end
      wr(IDX_OR_CLEAR, 8'h00);
      for (int c = 0; c < 8; c++) begin
         for (int sw = 0; sw < 2; sw++) begin
            wr(IDX_FORMAT, {5'h0, 3'(c)});
            wr(IDX_CHAN_ORDER, {7'h0, 1'(sw)});
            repeat (3) smp(3'(c), 1'(sw));
         end
      end
      wr(IDX_IRQ_MASK, 8'h00);
      pulse(3);
      rd(IDX_OR_FLAGS, 8'h08);
      rd(IDX_IRQ_STATUS, 8'h08);
      chk({31'h0, irq}, 32'h0, "masked irq");
      wr(IDX_IRQ_MASK, 8'h08);
      repeat (2) @(posedge clock);
      chk({31'h0, irq}, 32'h1, "irq");
      wr(IDX_IRQ_STATUS, 8'h08);
      repeat (2) @(posedge clock);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      rd(IDX_IRQ_STATUS, 8'h00);
      rd(IDX_OR_FLAGS, 8'h08);
      wr(IDX_OR_CLEAR, 8'h08);
      rd(IDX_OR_FLAGS, 8'h00);
      pulse(3);
      rd(IDX_OR_FLAGS, 8'h00);
      wr(IDX_OR_CLEAR, 8'h00);
      pulse(7);
      wr(IDX_OR_FLAGS, 8'hFF);
      rd(IDX_OR_FLAGS, 8'h80);
      rd(IDX_IRQ_STATUS, 8'h80);
      // zero input in offset binary gives zero out, so the first pattern word shows
      wr(IDX_FORMAT, 8'h00);
      wr(IDX_CHAN_ORDER, 8'h00);
      @(posedge clock);
      s_in <= '0;
      wr(IDX_PAT3_LO, 8'h3C);
      wr(IDX_PAT3_HI, 8'hA5);
      wr(IDX_PAT4_LO, 8'hC3);
      wr(IDX_PAT4_HI, 8'h5A);
      pat(8'h08, 1'b0);
      wr(IDX_TEST_MODE, 8'h00);
      pat(8'h88, 1'b1);
      wr(IDX_TEST_MODE, 8'h00);
      complete_run();
   end
endmodule
